//--- shared/lsl_pkg.sv
// Constants, field layout and a helper function for the LED sink latch control block.
// Assumes a single core clock; every pin input is resynchronised by the core.
package lsl_pkg;
  localparam int LSL_WORD_W = 25;
  localparam int LSL_CH_N = 24;
  localparam int LSL_GROUP_CH = 8;
  localparam int LSL_GROUP_N = 3;
  localparam int LSL_SCALE_W = 7;
  localparam int LSL_SEL_W = 3;
  localparam int LSL_SELECT_BIT = 24;
  localparam int LSL_RED_LSB = 0;
  localparam int LSL_GREEN_LSB = 7;
  localparam int LSL_BLUE_LSB = 14;
  localparam int LSL_SEL_LSB = 21;
  localparam int LSL_SHORT_MODE_BIT = 23;
  localparam int LSL_SCALE_DIV = 127;
  localparam int LSL_CUR_W = 16;
  localparam int LSL_FULL_SCALE_UA = 35000;
  // Positions of the pin inputs on the resynchroniser bus
  localparam int LSL_IN_SCLK = 0;
  localparam int LSL_IN_SIN = 1;
  localparam int LSL_IN_STROBE = 2;
  localparam int LSL_IN_FORCE_OFF = 3;
  localparam int LSL_IN_OVERHEAT = 4;
  localparam int LSL_IN_OPEN = 5;
  localparam int LSL_IN_SHORT = 29;
  localparam int LSL_IN_W = 53;

  // Sink current in microamps for one group scale code
  function automatic logic [LSL_CUR_W-1:0] lsl_scale_ua(input int full_ua,
                                                        input logic [LSL_SCALE_W-1:0] code);
    int prod;
    prod = (full_ua * int'(code)) / LSL_SCALE_DIV;
    return prod[LSL_CUR_W-1:0];
  endfunction : lsl_scale_ua
endpackage : lsl_pkg

//--- rtl/lsl_sync.sv
// Three-stage resynchroniser with agreement filter and rising-edge pulse.
// Assumes inputs are asynchronous to core_clk and slower than a few cycles.
`timescale 1ns/100ps
module lsl_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } lsl_sync_st_t;

  lsl_sync_st_t st_reg;
  lsl_sync_st_t st_next;

  // ************************************************************
  // A change counts only once stages two and three agree
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.stable = (st_reg.s2 & st_reg.s3) | (st_reg.stable & (st_reg.s2 | st_reg.s3));
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.stable;
  assign rise_out = st_reg.s2 & st_reg.s3 & ~st_reg.stable;
endmodule : lsl_sync

//--- rtl/lsl_core.sv
// Serial shift register, on-off and control latches, status readback and sink gating.
// Assumes all pin inputs and fault comparators are asynchronous to core_clk,
// and the shift clock runs well below a quarter of the core clock.
`timescale 1ns/100ps
module lsl_core
  import lsl_pkg::*;
#(
  parameter int FULL_SCALE_UA = LSL_FULL_SCALE_UA
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic shift_clk_pin,
  input wire logic serial_in_pin,
  input wire logic transfer_strobe,
  input wire logic force_off_pin,
  input wire logic overheat_in,
  input wire logic [LSL_CH_N-1:0] open_fault_detect,
  input wire logic [LSL_CH_N-1:0] short_fault_detect,
  output logic serial_out_pin,
  output logic [LSL_CH_N-1:0] sink_on,
  output logic [LSL_GROUP_CH-1:0] red_sink_channel,
  output logic [LSL_GROUP_CH-1:0] green_sink_channel,
  output logic [LSL_GROUP_CH-1:0] blue_sink_channel,
  output logic [LSL_SCALE_W-1:0] red_group_scale,
  output logic [LSL_SCALE_W-1:0] green_group_scale,
  output logic [LSL_SCALE_W-1:0] blue_group_scale,
  output logic [LSL_SEL_W-1:0] detect_select,
  output logic [LSL_CUR_W-1:0] red_current_ua,
  output logic [LSL_CUR_W-1:0] green_current_ua,
  output logic [LSL_CUR_W-1:0] blue_current_ua
);
  typedef struct packed {
    logic [LSL_WORD_W-1:0] serial_input_word;
    logic [LSL_CH_N-1:0] output_enable_bits;
    logic [LSL_CH_N-1:0] group_scale_and_detect;
    logic [LSL_CH_N-1:0] fault_hold;
    logic overheat_flag;
    logic fresh;
    logic [LSL_CH_N-1:0] sink;
    logic [LSL_GROUP_N-1:0][LSL_CUR_W-1:0] cur;
  } lsl_core_st_t;

  lsl_core_st_t st_reg;
  lsl_core_st_t st_next;

  logic [LSL_IN_W-1:0] raw_in;
  logic [LSL_IN_W-1:0] lvl;
  logic [LSL_IN_W-1:0] rise;
  logic sclk_rise;
  logic strobe_rise;
  logic sin_s;
  logic blank_s;
  logic hot_s;
  logic [LSL_CH_N-1:0] open_s;
  logic [LSL_CH_N-1:0] short_s;
  logic [LSL_CH_N-1:0] fault_live;
  logic [LSL_SCALE_W-1:0] scale_r;
  logic [LSL_SCALE_W-1:0] scale_g;
  logic [LSL_SCALE_W-1:0] scale_b;

  // ************************************************************
  // Pin resynchronisation
  // ************************************************************
  // Force-off travels inverted: a cleared resynchroniser then reads as blanked after reset
  assign raw_in = {short_fault_detect, open_fault_detect, overheat_in, ~force_off_pin,
                   transfer_strobe, serial_in_pin, shift_clk_pin};

  lsl_sync #(
    .W(LSL_IN_W)
  ) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(raw_in),
    .level_out(lvl),
    .rise_out(rise)
  );

  assign sclk_rise = rise[LSL_IN_SCLK];
  assign strobe_rise = rise[LSL_IN_STROBE];
  assign sin_s = lvl[LSL_IN_SIN];
  assign blank_s = ~lvl[LSL_IN_FORCE_OFF];
  assign hot_s = lvl[LSL_IN_OVERHEAT];
  assign open_s = lvl[LSL_IN_OPEN +: LSL_CH_N];
  assign short_s = lvl[LSL_IN_SHORT +: LSL_CH_N];

  // Fault bits only count for outputs programmed on
  assign fault_live = (st_reg.group_scale_and_detect[LSL_SHORT_MODE_BIT] ? short_s : open_s)
                      & st_reg.output_enable_bits;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    // Holder tracks live faults while outputs run, freezes when forced off
    if (!blank_s) begin
      st_next.fault_hold = fault_live;
    end
    // Overheat stays flagged until a strobe finds the die cool again
    st_next.overheat_flag = hot_s | (st_reg.overheat_flag & ~strobe_rise);
    if (sclk_rise) begin
      // Shift beats strobe in the same cycle; the strobe is then dropped
      st_next.serial_input_word = {st_reg.serial_input_word[LSL_WORD_W-2:0], sin_s};
      st_next.fresh = 1'b1;
    end else if (strobe_rise && st_reg.fresh) begin
      // A strobe without new shifted data is ignored
      st_next.fresh = 1'b0;
      if (!st_reg.serial_input_word[LSL_SELECT_BIT]) begin
        st_next.output_enable_bits = st_reg.serial_input_word[LSL_CH_N-1:0];
        st_next.serial_input_word = {st_reg.overheat_flag, st_reg.fault_hold};
      end else begin
        st_next.group_scale_and_detect = st_reg.serial_input_word[LSL_CH_N-1:0];
      end
    end
    // Overheat also shuts every sink, as the thermal shutdown does
    st_next.sink = (blank_s || hot_s) ? '0 : st_next.output_enable_bits;
    st_next.cur[0] = lsl_scale_ua(FULL_SCALE_UA,
      st_next.group_scale_and_detect[LSL_RED_LSB +: LSL_SCALE_W]);
    st_next.cur[1] = lsl_scale_ua(FULL_SCALE_UA,
      st_next.group_scale_and_detect[LSL_GREEN_LSB +: LSL_SCALE_W]);
    st_next.cur[2] = lsl_scale_ua(FULL_SCALE_UA,
      st_next.group_scale_and_detect[LSL_BLUE_LSB +: LSL_SCALE_W]);
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Data latches take no reset: their power-up content is undefined by design
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg.fresh <= 1'b0;
      st_reg.sink <= '0;
      st_reg.overheat_flag <= 1'b0;
      st_reg.fault_hold <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign serial_out_pin = st_reg.serial_input_word[LSL_SELECT_BIT];
  assign sink_on = st_reg.sink;
  assign scale_r = st_reg.group_scale_and_detect[LSL_RED_LSB +: LSL_SCALE_W];
  assign scale_g = st_reg.group_scale_and_detect[LSL_GREEN_LSB +: LSL_SCALE_W];
  assign scale_b = st_reg.group_scale_and_detect[LSL_BLUE_LSB +: LSL_SCALE_W];
  assign red_group_scale = scale_r;
  assign green_group_scale = scale_g;
  assign blue_group_scale = scale_b;
  assign detect_select = st_reg.group_scale_and_detect[LSL_SEL_LSB +: LSL_SEL_W];
  assign red_current_ua = st_reg.cur[0];
  assign green_current_ua = st_reg.cur[1];
  assign blue_current_ua = st_reg.cur[2];

  // Interleaved channel order across the three colour groups
  for (genvar k = 0; k < LSL_GROUP_CH; k++) begin : g_chan
    assign red_sink_channel[k] = st_reg.sink[LSL_GROUP_N*k];
    assign green_sink_channel[k] = st_reg.sink[LSL_GROUP_N*k+1];
    assign blue_sink_channel[k] = st_reg.sink[LSL_GROUP_N*k+2];
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_load_onoff;
    strobe_rise && !sclk_rise && st_reg.fresh && !st_reg.serial_input_word[LSL_SELECT_BIT];
  endsequence

  sequence s_load_ctl;
    strobe_rise && !sclk_rise && st_reg.fresh && st_reg.serial_input_word[LSL_SELECT_BIT];
  endsequence

  onoff_load_a: assert property (s_load_onoff |=>
      st_reg.output_enable_bits == $past(st_reg.serial_input_word[LSL_CH_N-1:0]))
    else $error("on-off latch did not load shifted word");

  ctl_load_a: assert property (s_load_ctl |=>
      st_reg.group_scale_and_detect == $past(st_reg.serial_input_word[LSL_CH_N-1:0])
      && st_reg.output_enable_bits === $past(st_reg.output_enable_bits))
    else $error("control latch load went wrong");

  scale_fields_a: assert property (s_load_ctl |=>
      red_group_scale == $past(st_reg.serial_input_word[6:0])
      && green_group_scale == $past(st_reg.serial_input_word[13:7])
      && blue_group_scale == $past(st_reg.serial_input_word[20:14]))
    else $error("group scale fields misplaced");

  scale_current_a: assert property (s_load_ctl |=>
      red_current_ua == lsl_scale_ua(FULL_SCALE_UA, $past(st_reg.serial_input_word[6:0])))
    else $error("red current not updated with scale");

  sink_follow_a: assert property (!blank_s && !hot_s |=>
      sink_on == st_reg.output_enable_bits)
    else $error("sinks do not follow on-off latch");

  force_off_a: assert property (blank_s |=> sink_on == '0)
    else $error("sink on while forced off");

  status_load_a: assert property (s_load_onoff |=>
      st_reg.serial_input_word == {$past(st_reg.overheat_flag), $past(st_reg.fault_hold)})
    else $error("status word not loaded");

  no_status_a: assert property (s_load_ctl |=> $stable(st_reg.serial_input_word))
    else $error("shift register changed on control load");

  fault_gate_a: assert property (!blank_s |=>
      (st_reg.fault_hold & ~$past(st_reg.output_enable_bits)) == '0)
    else $error("fault reported for an off output");

  shift_step_a: assert property (sclk_rise |=>
      serial_out_pin === $past(st_reg.serial_input_word[LSL_WORD_W-2])
      && st_reg.serial_input_word[0] == $past(sin_s))
    else $error("shift step wrong");

  stale_strobe_a: assert property (strobe_rise && !st_reg.fresh |=>
      st_reg.output_enable_bits === $past(st_reg.output_enable_bits)
      && st_reg.group_scale_and_detect === $past(st_reg.group_scale_and_detect))
    else $error("stale strobe changed a latch");

  // ************************************************************
  // Further guards on currents, the detect field, holders, sinks and the shift register
  // ************************************************************
  // Green and blue follow their scale fields on the same edge as red
  green_current_a: assert property (s_load_ctl |=>
      green_current_ua == lsl_scale_ua(FULL_SCALE_UA,
        $past(st_reg.serial_input_word[LSL_GREEN_LSB +: LSL_SCALE_W])))
    else $error("green current not updated with scale");

  blue_current_a: assert property (s_load_ctl |=>
      blue_current_ua == lsl_scale_ua(FULL_SCALE_UA,
        $past(st_reg.serial_input_word[LSL_BLUE_LSB +: LSL_SCALE_W])))
    else $error("blue current not updated with scale");

  detect_field_a: assert property (s_load_ctl |=>
      detect_select == $past(st_reg.serial_input_word[LSL_SEL_LSB +: LSL_SEL_W]))
    else $error("detect select field misplaced");

  // Forced off, the holder keeps what it saw last
  fault_freeze_a: assert property (blank_s |=>
      st_reg.fault_hold == $past(st_reg.fault_hold))
    else $error("fault holder moved while forced off");

  // A hot die blanks every sink and keeps the flag up
  overheat_off_a: assert property (hot_s |=> sink_on == '0 && st_reg.overheat_flag)
    else $error("sink on or flag clear while hot");

  // Without a shift or an accepted strobe the word must not move
  word_hold_a: assert property (!sclk_rise && !(strobe_rise && st_reg.fresh) |=>
      st_reg.serial_input_word === $past(st_reg.serial_input_word))
    else $error("shift register moved without a shift or load");
endmodule : lsl_core

//--- tb/lsl_ctrl_model.sv
// Controller model that drives the serial chain of the sink driver.
// Assumes core_clk at 100 MHz; the shift clock is 160 ns and idles low between frames.
`timescale 1ns/100ps
module lsl_ctrl_model (
  input wire logic core_clk,
  input wire logic serial_out_pin,
  output logic shift_clk_pin,
  output logic serial_in_pin,
  output logic transfer_strobe
);
  initial begin
    shift_clk_pin = 1'b0;
    serial_in_pin = 1'b0;
    transfer_strobe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Shifts a word top bit first, returns the bits that came out, then strobes
  task automatic send(input logic [24:0] w, output logic [24:0] rd);
    for (int i = 24; i >= 0; i--) begin
      @(posedge core_clk);
      shift_clk_pin <= 1'b0;
      serial_in_pin <= w[i];
      rd[i] = serial_out_pin;
      tick(8);
      shift_clk_pin <= 1'b1;
      tick(7);
    end
    @(posedge core_clk);
    shift_clk_pin <= 1'b0;
    // Released data line shows the inverse so a stale value cannot pass
    serial_in_pin <= ~w[0];
    tick(8);
    transfer_strobe <= 1'b1;
    tick(8);
    transfer_strobe <= 1'b0;
    tick(8);
  endtask : send

  // Pulses the strobe alone, with no bits shifted before it
  task automatic strobe_only();
    @(posedge core_clk);
    transfer_strobe <= 1'b1;
    tick(8);
    transfer_strobe <= 1'b0;
    tick(8);
  endtask : strobe_only
endmodule : lsl_ctrl_model

//--- tb/led_sink_latch_control_tb.sv
// Self-checking bench for the sink driver control path.
// Assumes lsl_pkg and the core; the controller model owns the serial pins.
`timescale 1ns/100ps
module led_sink_latch_control_tb;
  import lsl_pkg::*;
  logic core_clk, sys_rst, force_off_pin, overheat_in;
  logic shift_clk_pin, serial_in_pin, transfer_strobe, serial_out_pin;
  logic [23:0] open_fault_detect, short_fault_detect, sink_on, pat;
  logic [7:0] red_sink_channel, green_sink_channel, blue_sink_channel;
  logic [6:0] red_group_scale, green_group_scale, blue_group_scale;
  logic [2:0] detect_select;
  logic [15:0] red_current_ua, green_current_ua, blue_current_ua;
  logic [24:0] rd;
  int failures = 0;
  int total_checks = 0;

  lsl_core u_lsl_core (.core_clk, .sys_rst, .shift_clk_pin, .serial_in_pin,
    .transfer_strobe, .force_off_pin, .overheat_in, .open_fault_detect,
    .short_fault_detect, .serial_out_pin, .sink_on, .red_sink_channel,
    .green_sink_channel, .blue_sink_channel, .red_group_scale, .green_group_scale,
    .blue_group_scale, .detect_select, .red_current_ua, .green_current_ua,
    .blue_current_ua);
  lsl_ctrl_model u_lsl_ctrl_model (.core_clk, .serial_out_pin, .shift_clk_pin,
    .serial_in_pin, .transfer_strobe);

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  function automatic logic [15:0] ua(input logic [6:0] c);
    return 16'((LSL_FULL_SCALE_UA * int'(c)) / LSL_SCALE_DIV);
  endfunction : ua

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc

  // ****************************************
  // Scenarios
  // ****************************************
  // Every select code with boundary scales; blanked sinks stay off
  task automatic t_scales();
    logic [6:0] r, g, b;
    for (int i = 0; i < 8; i++) begin
      r = 7'(i * 18);
      g = 7'h7F - 7'(i);
      b = (i == 7) ? 7'h7F : 7'(i * 5);
      u_lsl_ctrl_model.send({1'b1, 3'(i), b, g, r}, rd);
      chk(detect_select, 25'(i));
      chk({red_group_scale, green_group_scale, blue_group_scale}, {r, g, b});
      chk(red_current_ua, ua(r));
      chk(green_current_ua, ua(g));
      chk(blue_current_ua, ua(b));
      chk(sink_on, 25'h0);
    end
  endtask : t_scales

  // On-off load, outputs kept at 0 while forced off
  task automatic t_onoff();
    u_lsl_ctrl_model.send({1'b0, pat}, rd);
    chk(sink_on, 25'h0);
    force_off_pin <= 1'b0;
    wait_cyc(8);
    chk(sink_on, pat);
    for (int k = 0; k < 8; k++) begin
      chk({red_sink_channel[k], green_sink_channel[k], blue_sink_channel[k]},
          {pat[3*k], pat[3*k+1], pat[3*k+2]});
    end
    chk(blue_group_scale, 25'h7F);
    force_off_pin <= 1'b1;
    wait_cyc(8);
    chk(sink_on, 25'h0);
    force_off_pin <= 1'b0;
    wait_cyc(8);
  endtask : t_onoff

  // Status readback in short then open mode, and the overheat flag
  task automatic t_status();
    short_fault_detect <= 24'hFF_00F0;
    open_fault_detect <= 24'h0F_0F0F;
    u_lsl_ctrl_model.send({1'b0, pat}, rd);
    u_lsl_ctrl_model.send(25'h160_0000, rd);
    chk(rd, {1'b0, pat & 24'hFF_00F0});
    chk(sink_on, pat);
    u_lsl_ctrl_model.send({1'b0, pat}, rd);
    chk(rd, 25'h160_0000);
    chk(red_current_ua, 25'h0);
    u_lsl_ctrl_model.send({1'b0, pat}, rd);
    chk(rd, {1'b0, pat & 24'h0F_0F0F});
    overheat_in <= 1'b1;
    wait_cyc(8);
    u_lsl_ctrl_model.send({1'b0, pat}, rd);
    overheat_in <= 1'b0;
    u_lsl_ctrl_model.send({1'b0, pat}, rd);
    chk(rd[24], 25'h1);
    // The strobe that reads the flag back clears it once the die is cool
    u_lsl_ctrl_model.send({1'b0, pat}, rd);
    u_lsl_ctrl_model.send({1'b0, pat}, rd);
    chk(rd, {1'b0, pat & 24'h0F_0F0F});
  endtask : t_status

  // A strobe with no new shifted bits is ignored
  task automatic t_stale();
    u_lsl_ctrl_model.strobe_only();
    chk(sink_on, pat);
  endtask : t_stale

  // ****************************************
  // Clock, reset and sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    wait_cyc(100000);
    failures++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    force_off_pin = 1'b1;
    overheat_in = 1'b0;
    open_fault_detect = 24'h0;
    short_fault_detect = 24'h0;
    pat = 24'hA5_C396;
    wait_cyc(5);
    sys_rst <= 1'b0;
    wait_cyc(2);
    t_scales();
    t_onoff();
    t_status();
    t_stale();
    summarize();
  end
endmodule : led_sink_latch_control_tb
